// ### design/smc_motion.sv
// Purpose: stepper motion core with phase or step/dir outputs
// Assumes: single 50 MHz clock, asynchronous pins synchronised here
// Notes: registers on a plain strobe port, read data one cycle later
`timescale 1ns/100ps
module smc_motion import smc_pkg::*; #(
	parameter int MS_CYC = TICK_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [15:0] reg_rdata,
	input wire logic abort_n,
	input wire logic trigger_n,
	input wire logic pause_n,
	input wire logic limit_n,
	input wire logic home,
	input wire logic unit_select_lsb,
	input wire logic unit_select_1,
	input wire logic unit_select_2,
	input wire logic unit_select_msb,
	output logic phase_out_1,
	output logic phase_out_2,
	output logic phase_out_3,
	output logic phase_out_4,
	output logic winding_en_a_or_step_pulse,
	output logic winding_en_b_or_direction,
	output logic power_save_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_RUN} smc_state_type;

	function automatic logic [3:0] phase_pat(input logic [1:0] m, input logic [2:0] i);
		logic [2:0] k;
		logic [3:0] t;
		k = i;
		if (m == MODE_FULL) begin
			k = {i[2:1], 1'b1};
		end else if (m == MODE_MONO) begin
			k = {i[2:1], 1'b0};
		end
		case (k)
			3'd0: t = 4'b0001;
			3'd1: t = 4'b0011;
			3'd2: t = 4'b0010;
			3'd3: t = 4'b0110;
			3'd4: t = 4'b0100;
			3'd5: t = 4'b1100;
			3'd6: t = 4'b1000;
			default: t = 4'b1001;
		endcase
		return t;
	endfunction

	function automatic logic [13:0] clamp_rate(input logic [19:0] r);
		logic [13:0] c;
		c = r[13:0];
		if (r < 20'(RATE_MIN)) begin
			c = RATE_MIN;
		end else if (r > 20'(RATE_MAX)) begin
			c = RATE_MAX;
		end
		return c;
	endfunction

	logic [8:0] meta_q;
	logic [8:0] sync_q;
	logic abort_prev_q;
	logic [7:0] cfg_q;
	logic [15:0] start_q;
	logic [15:0] target_q;
	logic [15:0] accel_q;
	logic [15:0] steps_q;
	logic [15:0] idle_ms_q;
	logic dir_q;
	logic lim_cw_q;
	logic lim_ccw_q;
	logic home_q;
	logic [7:0] mem [0:FIFO_DEPTH-1];
	logic [6:0] wr_ptr_q;
	logic [6:0] rd_ptr_q;
	logic [7:0] fifo_cnt_q;
	smc_state_type state_q;
	logic [13:0] rate_q;
	logic [26:0] acc_q;
	logic [15:0] remain_q;
	logic [15:0] ramp_q;
	logic signed [15:0] pos_q;
	logic [2:0] idx_q;
	logic [31:0] ms_cnt_q;
	logic [15:0] idle_cnt_q;
	logic [7:0] pulse_q;

	// synchronised pins
	wire abort_s = sync_q[0];
	wire trig_s = sync_q[1];
	wire pause_s = sync_q[2];
	wire limit_s = sync_q[3];
	wire home_s = sync_q[4];
	wire [3:0] unit_s = sync_q[8:5];

	wire ext = cfg_q[CFG_EXT];
	wire [1:0] mode = cfg_q[1:0];
	wire prof = cfg_q[CFG_PROF];
	wire wr_ctl = reg_we && reg_addr == REG_CTRL;
	wire go = wr_ctl && reg_wdata[CTL_GO] && state_q == ST_IDLE;
	wire halt = wr_ctl && reg_wdata[CTL_HALT];
	wire abort_fall = abort_prev_q && !abort_s;
	wire fifo_empty = fifo_cnt_q == 8'h00;
	wire fifo_full = fifo_cnt_q == 8'(FIFO_DEPTH);
	wire flush = abort_fall || (wr_ctl && reg_wdata[CTL_FLUSH]);
	wire ms_tick = ms_cnt_q == 32'(MS_CYC - 1);
	wire [26:0] acc_sum = acc_q + 27'(rate_q);
	wire step_now = state_q == ST_RUN && pause_s && acc_sum >= CLK_HZ;
	wire hit_limit = state_q != ST_IDLE && !limit_s;
	wire hit_home = state_q != ST_IDLE && cfg_q[CFG_HOME] && home_s;
	wire last_step = step_now && remain_q == 16'h0001;
	wire push = reg_we && reg_addr == REG_FIFO && !fifo_full;
	wire pop = step_now && prof && !fifo_empty;
	wire [3:0] pat = phase_pat(mode, idx_q);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 9'h1FF;
			sync_q <= 9'h1FF;
			abort_prev_q <= 1'b1;
		end else begin
			meta_q <= {unit_select_msb, unit_select_2, unit_select_1, unit_select_lsb,
				home, limit_n, pause_n, trigger_n, abort_n};
			sync_q <= meta_q;
			abort_prev_q <= abort_s;
		end
	end

	// configuration registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= 8'h00;
			start_q <= RST_START;
			target_q <= RST_TARGET;
			accel_q <= 16'h0000;
			steps_q <= 16'h0000;
			idle_ms_q <= RST_IDLE;
		end else if (reg_we) begin
			case (reg_addr)
				REG_CONFIG: cfg_q <= reg_wdata[7:0];
				REG_START: start_q <= reg_wdata;
				REG_TARGET: target_q <= reg_wdata;
				REG_ACCEL: accel_q <= reg_wdata;
				REG_STEPS: steps_q <= reg_wdata;
				REG_IDLE: idle_ms_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// sticky stop flags, set wins over clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lim_cw_q <= 1'b0;
			lim_ccw_q <= 1'b0;
			home_q <= 1'b0;
		end else begin
			if (reg_we && reg_addr == REG_STATUS) begin
				lim_cw_q <= lim_cw_q & ~reg_wdata[2];
				lim_ccw_q <= lim_ccw_q & ~reg_wdata[3];
				home_q <= home_q & ~reg_wdata[4];
			end
			if (hit_limit && dir_q) begin
				lim_cw_q <= 1'b1;
			end
			if (hit_limit && !dir_q) begin
				lim_ccw_q <= 1'b1;
			end
			if (hit_home) begin
				home_q <= 1'b1;
			end
		end
	end

	// profile fifo
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_q] <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= 7'h00;
			rd_ptr_q <= 7'h00;
			fifo_cnt_q <= 8'h00;
		end else if (flush) begin
			wr_ptr_q <= 7'h00;
			rd_ptr_q <= 7'h00;
			fifo_cnt_q <= 8'h00;
		end else begin
			wr_ptr_q <= wr_ptr_q + 7'(push);
			rd_ptr_q <= rd_ptr_q + 7'(pop);
			fifo_cnt_q <= fifo_cnt_q + 8'(push) - 8'(pop);
		end
	end

	// motion sequencer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			dir_q <= 1'b0;
			remain_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (go && steps_q != 16'h0000) begin
						state_q <= ST_WAIT_TRIG;
						dir_q <= reg_wdata[CTL_CW];
						remain_q <= steps_q;
					end
				end
				ST_WAIT_TRIG: begin
					if (!trig_s) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (step_now) begin
						remain_q <= remain_q - 16'h0001;
					end
					if (last_step) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			if (abort_fall || halt || hit_limit || hit_home) begin
				state_q <= ST_IDLE;
			end
		end
	end

	// rate generator and ramps
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rate_q <= RATE_MIN;
			acc_q <= 27'h000_0000;
			ramp_q <= 16'h0000;
		end else if (go) begin
			rate_q <= clamp_rate(20'(start_q));
			acc_q <= 27'h000_0000;
			ramp_q <= 16'h0000;
		end else if (state_q == ST_RUN) begin
			if (pause_s) begin
				acc_q <= step_now ? acc_sum - CLK_HZ : acc_sum;
			end
			if (pop) begin
				rate_q <= clamp_rate(20'(mem[rd_ptr_q]) * 20'(PROF_SCALE));
			end else if (!prof && ms_tick) begin
				if (remain_q <= ramp_q) begin
					// floor at zero so a large accel cannot wrap to the top rate
					rate_q <= clamp_rate((20'(accel_q) >= 20'(rate_q)) ? 20'h0_0000 :
						20'(rate_q) - 20'(accel_q));
				end else if (rate_q < clamp_rate(20'(target_q))) begin
					rate_q <= clamp_rate(20'(rate_q) + 20'(accel_q));
				end else if (rate_q > clamp_rate(20'(target_q))) begin
					rate_q <= clamp_rate(20'(target_q));
				end
			end
			if (step_now && !prof && rate_q < clamp_rate(20'(target_q))) begin
				ramp_q <= ramp_q + 16'h0001;
			end
		end
	end

	// position and phase index
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= 16'sh0000;
			idx_q <= 3'h0;
		end else if (step_now) begin
			pos_q <= dir_q ? pos_q + 16'sh0001 : pos_q - 16'sh0001;
			if (mode == MODE_HALF) begin
				idx_q <= dir_q ? idx_q + 3'h1 : idx_q - 3'h1;
			end else begin
				idx_q <= dir_q ? idx_q + 3'h2 : idx_q - 3'h2;
			end
		end
	end

	// millisecond tick
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_q <= 32'h0000_0000;
		end else begin
			ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
		end
	end

	// idle timer for power save
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_q <= 16'h0000;
			power_save_out <= 1'b1;
		end else if (state_q != ST_IDLE || !cfg_q[CFG_PSAVE]) begin
			idle_cnt_q <= 16'h0000;
			power_save_out <= 1'b1;
		end else if (idle_cnt_q >= idle_ms_q) begin
			power_save_out <= 1'b0;
		end else if (ms_tick) begin
			idle_cnt_q <= idle_cnt_q + 16'h0001;
		end
	end

	// output pins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_q <= 8'h00;
			{phase_out_4, phase_out_3, phase_out_2, phase_out_1} <= 4'h0;
			winding_en_a_or_step_pulse <= 1'b0;
			winding_en_b_or_direction <= 1'b0;
		end else begin
			pulse_q <= step_now ? 8'(PULSE_CYC) : pulse_q - 8'(pulse_q != 8'h00);
			if (ext) begin
				{phase_out_4, phase_out_3, phase_out_2, phase_out_1} <= 4'h0;
				winding_en_a_or_step_pulse <= step_now || pulse_q > 8'h01;
				winding_en_b_or_direction <= dir_q;
			end else begin
				{phase_out_4, phase_out_3, phase_out_2, phase_out_1} <= pat;
				winding_en_a_or_step_pulse <= pat[0] | pat[2];
				winding_en_b_or_direction <= pat[1] | pat[3];
			end
		end
	end

	// register read port
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_re) begin
			case (reg_addr)
				REG_CONFIG: reg_rdata <= {8'h00, cfg_q};
				REG_START: reg_rdata <= start_q;
				REG_TARGET: reg_rdata <= target_q;
				REG_ACCEL: reg_rdata <= accel_q;
				REG_STEPS: reg_rdata <= remain_q;
				REG_STATUS: reg_rdata <= {8'h00, !pause_s, fifo_full, fifo_empty, home_q,
					lim_ccw_q, lim_cw_q, state_q == ST_WAIT_TRIG, state_q != ST_IDLE};
				REG_POS: reg_rdata <= pos_q;
				REG_FIFO: reg_rdata <= {8'h00, fifo_cnt_q};
				REG_IDLE: reg_rdata <= idle_ms_q;
				REG_UNIT: reg_rdata <= {12'h000, unit_s};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_halted;
		state_q == ST_IDLE;
	endsequence
	sequence s_pulse_high;
		winding_en_a_or_step_pulse [*8];
	endsequence

	property p_abort_stop;
		abort_fall |=> s_halted ##0 fifo_empty;
	endproperty
	a_abort_stop: assert property (p_abort_stop) else $error("abort did not stop");
	property p_step_pulse;
		ext && step_now |=> s_pulse_high;
	endproperty
	a_step_pulse: assert property (p_step_pulse) else $error("step pulse short");
	property p_dir_level;
		ext && state_q == ST_RUN && $stable(ext) |-> winding_en_b_or_direction == dir_q;
	endproperty
	a_dir_level: assert property (p_dir_level) else $error("direction wrong");
	property p_enable_a;
		rst_n && !ext ##1 !ext |-> winding_en_a_or_step_pulse == ($past(pat[0]) | $past(pat[2]));
	endproperty
	a_enable_a: assert property (p_enable_a) else $error("enable a wrong");
	property p_psave_busy;
		state_q != ST_IDLE |=> power_save_out;
	endproperty
	a_psave_busy: assert property (p_psave_busy) else $error("power save while busy");
	property p_trigger_wait;
		state_q == ST_WAIT_TRIG && trig_s |=> state_q != ST_RUN;
	endproperty
	a_trigger_wait: assert property (p_trigger_wait) else $error("started w/o trigger");
	property p_pause_hold;
		!pause_s |=> $stable(pos_q);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("moved while paused");
	property p_limit_cw;
		state_q == ST_RUN && !limit_s && dir_q |=> s_halted ##0 lim_cw_q;
	endproperty
	a_limit_cw: assert property (p_limit_cw) else $error("limit not handled");
	property p_home_stop;
		state_q == ST_RUN && cfg_q[CFG_HOME] && home_s |=> s_halted ##0 home_q;
	endproperty
	a_home_stop: assert property (p_home_stop) else $error("home not handled");
	property p_rate_range;
		state_q == ST_RUN |-> rate_q >= RATE_MIN && rate_q <= RATE_MAX;
	endproperty
	a_rate_range: assert property (p_rate_range) else $error("rate out of range");
	property p_rate_hold;
		state_q == ST_RUN && !prof && !ms_tick |=> $stable(rate_q);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate moved off tick");
	property p_full_two;
		mode == MODE_FULL |-> $countones(pat) == 2;
	endproperty
	a_full_two: assert property (p_full_two) else $error("full step not two");
endmodule // smc_motion

// ### design/smc_pkg.sv
// Purpose: constants for the stepper motion core
// Assumes: 50 MHz mclk, 16-bit register port
// Notes: register map, field positions, timing counts
package smc_pkg;
	localparam int DATA_W = 16;
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_START = 4'h1;
	localparam logic [3:0] REG_TARGET = 4'h2;
	localparam logic [3:0] REG_ACCEL = 4'h3;
	localparam logic [3:0] REG_STEPS = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [3:0] REG_POS = 4'h7;
	localparam logic [3:0] REG_FIFO = 4'h8;
	localparam logic [3:0] REG_IDLE = 4'h9;
	localparam logic [3:0] REG_UNIT = 4'hA;
	localparam int CFG_EXT = 3;
	localparam int CFG_PSAVE = 4;
	localparam int CFG_HOME = 5;
	localparam int CFG_PROF = 6;
	localparam int CTL_GO = 0;
	localparam int CTL_CW = 1;
	localparam int CTL_HALT = 2;
	localparam int CTL_FLUSH = 3;
	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_MONO = 2'h1;
	localparam logic [1:0] MODE_HALF = 2'h2;
	localparam logic [13:0] RATE_MIN = 14'h0010;
	localparam logic [13:0] RATE_MAX = 14'h2134;
	localparam logic [26:0] CLK_HZ = 27'h2FA_F080;
	localparam logic [5:0] PROF_SCALE = 6'h22;
	localparam int FIFO_DEPTH = 128;
	localparam int CLK_MHZ = 50;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int PULSE_NS = 2000;
	localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;
	localparam logic [15:0] RST_START = 16'h0010;
	localparam logic [15:0] RST_TARGET = 16'h0010;
	localparam logic [15:0] RST_IDLE = 16'h03E8;
endpackage

// ### verification/smc_drive_model.sv
// Purpose: external step/direction driver model that counts pulses
// Assumes: step and direction pins registered on mclk
// Notes: counts only while the bench reports external driver mode
`timescale 1ns/100ps
module smc_drive_model (
	input wire logic mclk,
	input wire logic ext,
	input wire logic step,
	input wire logic dir,
	output int n_cw,
	output int n_ccw,
	output int n_bad
);
	logic step_q = 1'b0;
	logic dir_q = 1'b0;
	int cw_q = 0;
	int ccw_q = 0;
	int bad_q = 0;
	assign n_cw = cw_q;
	assign n_ccw = ccw_q;
	assign n_bad = bad_q;
	always @(posedge mclk) begin
		step_q <= step;
		dir_q <= dir;
		// one count per rising step edge, split by direction level
		if (ext && step && !step_q) begin
			if (dir) begin
				cw_q <= cw_q + 1;
			end else begin
				ccw_q <= ccw_q + 1;
			end
			// direction must already be steady the cycle before
			if (dir !== dir_q) begin
				bad_q <= bad_q + 1;
			end
		end
	end
endmodule // smc_drive_model

// ### verification/tb_stepper_motion_io_control.sv
// Purpose: self-checking bench for the stepper motion core
// Assumes: 50 MHz mclk, MS_CYC shortened to 50 cycles
// Notes: runs at full rate so each step takes about 5900 cycles
`timescale 1ns/100ps
module tb_stepper_motion_io_control import smc_pkg::*;;
	logic mclk = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
	logic [3:0] reg_addr = 4'h0, u = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, st;
	logic abort_n = 1'b1, trigger_n = 1'b1, pause_n = 1'b1, limit_n = 1'b1, home = 1'b0;
	logic ph1, ph2, ph3, ph4, en_a, en_b, psave, ext_mode = 1'b0;
	int mismatches = 0, n_tests = 0, seed = 26, n, i, k, m, j, ones0;
	int n_cw, n_ccw, n_bad;
	initial forever #10 mclk = ~mclk;
	smc_motion #(.MS_CYC(50)) uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.abort_n(abort_n), .trigger_n(trigger_n), .pause_n(pause_n), .limit_n(limit_n),
		.home(home), .unit_select_lsb(u[0]), .unit_select_1(u[1]), .unit_select_2(u[2]),
		.unit_select_msb(u[3]), .phase_out_1(ph1), .phase_out_2(ph2), .phase_out_3(ph3),
		.phase_out_4(ph4), .winding_en_a_or_step_pulse(en_a),
		.winding_en_b_or_direction(en_b), .power_save_out(psave));
	smc_drive_model drv (.mclk(mclk), .ext(ext_mode), .step(en_a), .dir(en_b),
		.n_cw(n_cw), .n_ccw(n_ccw), .n_bad(n_bad));
	function automatic int exp_ones(input int mode);
		return (mode == 0) ? 2 : (mode == 1) ? 1 : 3;
	endfunction
	function automatic int ph_ones();
		return int'(ph1) + int'(ph2) + int'(ph3) + int'(ph4);
	endfunction
	task automatic results();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge mclk);
		reg_we <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge mclk);
		reg_re <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge mclk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	task automatic move(input logic cw, input logic [15:0] steps);
		wr(REG_STEPS, steps);
		wr(REG_CTRL, {14'h0000, cw, 1'b1});
	endtask
	task automatic wait_idle();
		int p;
		for (p = 0; p < 20000; p++) begin
			rd(REG_STATUS, st);
			if (st[0] === 1'b0) break;
		end
		if (p == 20000) begin
			mismatches++;
			$display("FAIL %0t motion never finished", $time);
			results();
		end
	endtask
	initial begin
		cyc(5);
		chk({9'h000, ph1, ph2, ph3, ph4, en_a, en_b, psave}, 16'h0001);
		rst_n <= 1'b1;
		@(posedge mclk);
		rchk(REG_START, RST_START);
		rchk(REG_IDLE, RST_IDLE);
		for (k = 0; k < 2; k++) begin
			u <= 4'($random(seed));
			cyc(4);
			rchk(REG_UNIT, {12'h000, u});
		end
		ext_mode <= 1'b1;
		wr(REG_CONFIG, 16'h0008);
		wr(REG_START, {2'b00, RATE_MAX});
		wr(REG_TARGET, {2'b00, RATE_MAX});
		wr(REG_ACCEL, 16'h0064);
		n = ($random(seed) & 3) + 1;
		move(1'b1, 16'(n));
		cyc(40);
		rd(REG_STATUS, st);
		chk(st & 16'h0003, 16'h0003);
		rchk(REG_POS, 16'h0000);
		trigger_n <= 1'b0;
		wait_idle();
		chk(16'(n_cw), 16'(n));
		rchk(REG_POS, 16'(n));
		pause_n <= 1'b0;
		move(1'b0, 16'h0002);
		cyc(8000);
		rchk(REG_POS, 16'(n));
		chk(16'(n_ccw), 16'h0000);
		pause_n <= 1'b1;
		wait_idle();
		chk(16'(n_ccw), 16'h0002);
		rchk(REG_POS, 16'(n - 2));
		chk(16'(n_bad), 16'h0000);
		for (k = 0; k < 3; k++) begin
			wr(REG_CONFIG, (k == 2) ? 16'h0028 : 16'h0008);
			move(k != 1, 16'h0064);
			cyc(100);
			if (k == 2) home <= 1'b1;
			else limit_n <= 1'b0;
			cyc(8);
			rd(REG_STATUS, st);
			chk(st & 16'h001D, 16'h0004 << k);
			home <= 1'b0;
			limit_n <= 1'b1;
			cyc(4);
			wr(REG_STATUS, 16'h001C);
		end
		wr(REG_CONFIG, 16'h0008);
		move(1'b1, 16'h0064);
		for (k = 0; k < 3; k++) wr(REG_FIFO, 16'($random(seed)));
		rchk(REG_FIFO, 16'h0003);
		abort_n <= 1'b0;
		cyc(6);
		rd(REG_STATUS, st);
		chk(st & 16'h0021, 16'h0020);
		rchk(REG_FIFO, 16'h0000);
		wr(REG_CONFIG, 16'h0048);
		for (k = 0; k < 3; k++) wr(REG_FIFO, 16'h00FA);
		move(1'b1, 16'h0002);
		wait_idle();
		rchk(REG_FIFO, 16'h0001);
		move(1'b1, 16'h0064);
		wr(REG_FIFO, 16'($random(seed)));
		wr(REG_CTRL, 16'h000C);
		cyc(2);
		rd(REG_STATUS, st);
		chk(st & 16'h0021, 16'h0020);
		abort_n <= 1'b1;
		ext_mode <= 1'b0;
		for (m = 0; m < 3; m++) begin
			wr(REG_CONFIG, 16'(m));
			ones0 = 0;
			for (j = 0; j < ((m == 2) ? 2 : 1); j++) begin
				move(1'b1, 16'h0001);
				wait_idle();
				ones0 += ph_ones();
				chk({15'h0000, en_a}, {15'h0000, ph1 | ph3});
				chk({15'h0000, en_b}, {15'h0000, ph2 | ph4});
			end
			chk(16'(ones0), 16'(exp_ones(m)));
		end
		wr(REG_IDLE, 16'h0002);
		wr(REG_CONFIG, 16'h0010);
		chk({15'h0000, psave}, 16'h0001);
		for (i = 0; i < 2000 && psave !== 1'b0; i++) @(posedge mclk);
		chk({15'h0000, psave}, 16'h0000);
		wr(REG_CONFIG, 16'h0008);
		rst_n <= 1'b0;
		cyc(2);
		chk({9'h000, ph1, ph2, ph3, ph4, en_a, en_b, psave}, 16'h0001);
		rst_n <= 1'b1;
		@(posedge mclk);
		rchk(REG_CONFIG, 16'h0000);
		rchk(REG_POS, 16'h0000);
		results();
	end
endmodule // tb_stepper_motion_io_control
